// ===== logic/port_rb_pkg.sv
// constants and types for the port read-back and self-test block
package port_rb_pkg;
    localparam int          N_PINS         = 8;
    localparam int          N_UART         = 3;
    localparam int          ADDR_W         = 4;
    // register offsets
    localparam logic [3:0]  OFF_PORT_DATA  = 4'h0;
    localparam logic [3:0]  OFF_PORT_DIR   = 4'h1;
    localparam logic [3:0]  OFF_WAKE_EN    = 4'h2;
    localparam logic [3:0]  OFF_ANALOG_SEL = 4'h3;
    localparam logic [3:0]  OFF_OUTFN_SEL  = 4'h4;
    localparam logic [3:0]  OFF_RX_SEL     = 4'h5;
    localparam logic [3:0]  OFF_UNLOCK     = 4'h6;
    localparam logic [3:0]  OFF_BITOP      = 4'h7;
    localparam logic [3:0]  OFF_POWER      = 4'h8;
    localparam logic [3:0]  OFF_IRQ_STAT   = 4'h9;
    localparam logic [3:0]  OFF_IRQ_MASK   = 4'hA;
    // reset values
    localparam logic [7:0]  PORT_RST       = 8'hFF;
    localparam logic [7:0]  ZERO_RST       = 8'h00;
    localparam logic [2:0]  RX_SEL_RST     = 3'h0;
    // unlock key 11001010
    localparam logic [7:0]  UNLOCK_KEY     = 8'hCA;
    // bit operation command fields
    localparam int          BITOP_IDX_LSB  = 0;
    localparam int          BITOP_SET_POS  = 3;
    localparam int          BITOP_TGT_POS  = 4;
    // power register field
    localparam int          POWER_SLEEP_POS = 0;
    // interrupt status fields
    localparam int          STAT_WAKE_POS  = 0;
    localparam int          STAT_RB_POS    = 1;

    typedef enum logic {
        PWR_RUN,
        PWR_SLEEP
    } power_t;
endpackage

// ===== logic/level_sync.sv
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 11
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_t;

    sync_t sync_reg;
    sync_t sync_next;

    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = d_in;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q_out = sync_reg.s2;
endmodule

// ===== logic/port_readback_selftest.sv
// port read-back self-test, rx source routing, port registers and wake-up
//
// Behaviour
// - writing key 11001010 to the unlock register enables read-back mode.
// - with read-back off, pins follow their selected function unchanged.
// - with read-back on, a port read returns the pin levels.
// - read-back off, output pin reads latch when direction 0, zero when 1.
// - read-back off, analogue path is off unless converter input selected.
// - read-back on forces analogue paths on; digital output feeds converter.
// - reset sets port data and direction registers to all ones.
// - bit set or clear reads whole port or direction register, modifies bit, writes byte back.
// - in sleep, falling edge on a wake-enabled pin wakes the device.
// - rx select bit picks default pin at 0, alternate pin at 1.
// - rx select bits 7 to 3 are not implemented and read as zero.
`timescale 1ns/1ps
module port_readback_selftest
    import port_rb_pkg::*;
(
    input  wire logic                    CORE_CLK_IN,
    input  wire logic                    ARST_N_IN,
    input  wire logic [port_rb_pkg::ADDR_W-1:0] ADDR_IN,
    input  wire logic [7:0]              WDATA_IN,
    input  wire logic                    WR_IN,
    input  wire logic                    RD_IN,
    output logic      [7:0]              RDATA_OUT,
    input  wire logic [port_rb_pkg::N_PINS-1:0] PORT_PIN_IN,
    output logic      [port_rb_pkg::N_PINS-1:0] PORT_PIN_OUT,
    output logic      [port_rb_pkg::N_PINS-1:0] PORT_PIN_OE_OUT,
    output logic      [port_rb_pkg::N_PINS-1:0] ADC_PATH_ON_OUT,
    input  wire logic [port_rb_pkg::N_UART-1:0] UART_RX_DEF_IN,
    input  wire logic [port_rb_pkg::N_UART-1:0] UART_RX_ALT_IN,
    output logic      [port_rb_pkg::N_UART-1:0] UART_RX_OUT,
    output logic                         READ_BACK_EN_OUT,
    output logic                         SLEEP_OUT,
    output logic                         IRQ_OUT
);
    import port_rb_pkg::*;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] wake_en;
        logic [7:0] analog_sel;
        logic [7:0] outfn_sel;
        logic [7:0] unlock;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic [7:0] pin_prev;
        logic [7:0] rdata;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] adc_path;
        logic [2:0] rx_sel;
        logic [2:0] uart_rx;
        logic       read_back_enable;
        logic       irq;
        power_t     power;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic [N_PINS-1:0] pin_sync;
    logic [N_UART-1:0] rx_def_sync;
    logic [N_UART-1:0] rx_alt_sync;
    logic [7:0]        port_val;
    logic [7:0]        fall;
    logic [7:0]        bitop_src;
    logic [7:0]        bitop_val;
    logic [2:0]        bitop_idx;
    logic              wr_hit_unlock;

    // pins and uart inputs cross in through two flops
    level_sync #(
        .WIDTH (N_PINS + 2 * N_UART)
    ) u_sync (
        .clk_in    (CORE_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .d_in      ({UART_RX_ALT_IN, UART_RX_DEF_IN, PORT_PIN_IN}),
        .q_out     ({rx_alt_sync, rx_def_sync, pin_sync})
    );

    // per-pin read value of the port
    genvar gi;
    generate
        for (gi = 0; gi < N_PINS; gi++) begin : g_pin
            assign port_val[gi] = st_reg.read_back_enable ? pin_sync[gi] :
                                  st_reg.analog_sel[gi]   ? 1'b0 :
                                  st_reg.outfn_sel[gi]    ?
                                  (st_reg.dir[gi] ? 1'b0 : st_reg.data[gi]) :
                                  pin_sync[gi];
            assign fall[gi] = st_reg.pin_prev[gi] & ~pin_sync[gi];
        end
    endgenerate

    // read-modify-write source and result
    assign bitop_idx = WDATA_IN[BITOP_IDX_LSB +: 3];
    assign bitop_src = WDATA_IN[BITOP_TGT_POS] ? st_reg.dir : port_val;
    always_comb begin
        bitop_val            = bitop_src;
        bitop_val[bitop_idx] = WDATA_IN[BITOP_SET_POS];
    end

    assign wr_hit_unlock = WR_IN && (ADDR_IN == OFF_UNLOCK);

    always_comb begin
        st_next          = st_reg;
        st_next.pin_prev = pin_sync;
        st_next.rdata    = ZERO_RST;
        // register writes
        if (WR_IN) begin
            case (ADDR_IN)
                OFF_PORT_DATA: begin
                    st_next.data = WDATA_IN;
                end
                OFF_PORT_DIR: begin
                    st_next.dir = WDATA_IN;
                end
                OFF_WAKE_EN: begin
                    st_next.wake_en = WDATA_IN;
                end
                OFF_ANALOG_SEL: begin
                    st_next.analog_sel = WDATA_IN;
                end
                OFF_OUTFN_SEL: begin
                    st_next.outfn_sel = WDATA_IN;
                end
                OFF_RX_SEL: begin
                    st_next.rx_sel = WDATA_IN[2:0];
                end
                OFF_UNLOCK: begin
                    st_next.unlock = WDATA_IN;
                end
                OFF_BITOP: begin
                    if (WDATA_IN[BITOP_TGT_POS]) begin
                        st_next.dir = bitop_val;
                    end else begin
                        st_next.data = bitop_val;
                    end
                end
                OFF_POWER: begin
                    if (WDATA_IN[POWER_SLEEP_POS]) begin
                        st_next.power = PWR_SLEEP;
                    end
                end
                OFF_IRQ_MASK: begin
                    st_next.irq_mask = WDATA_IN;
                end
                default: begin
                end
            endcase
        end
        // register reads, data one cycle later
        if (RD_IN) begin
            case (ADDR_IN)
                OFF_PORT_DATA:  st_next.rdata = port_val;
                OFF_PORT_DIR:   st_next.rdata = st_reg.dir;
                OFF_WAKE_EN:    st_next.rdata = st_reg.wake_en;
                OFF_ANALOG_SEL: st_next.rdata = st_reg.analog_sel;
                OFF_OUTFN_SEL:  st_next.rdata = st_reg.outfn_sel;
                OFF_RX_SEL:     st_next.rdata = {5'h0_0, st_reg.rx_sel};
                OFF_UNLOCK:     st_next.rdata = st_reg.unlock;
                OFF_POWER:      st_next.rdata = {7'h0_0, st_reg.power == PWR_SLEEP};
                OFF_IRQ_STAT:   st_next.rdata = st_reg.irq_stat;
                OFF_IRQ_MASK:   st_next.rdata = st_reg.irq_mask;
                default:        st_next.rdata = ZERO_RST;
            endcase
            if (ADDR_IN == OFF_IRQ_STAT) begin
                st_next.irq_stat = ZERO_RST;
            end
        end
        // key compare on the new unlock value
        st_next.read_back_enable = (st_next.unlock == UNLOCK_KEY);
        // wake on falling edge of an enabled pin
        case (st_reg.power)
            PWR_RUN: begin
            end
            PWR_SLEEP: begin
                if ((fall & st_reg.wake_en) != 8'h00) begin
                    st_next.power                  = PWR_RUN;
                    st_next.irq_stat[STAT_WAKE_POS] = 1'b1;
                end
            end
            default: begin
                st_next.power = PWR_RUN;
            end
        endcase
        // entering read-back mode is an event; set beats read clear
        if (st_next.read_back_enable && !st_reg.read_back_enable) begin
            st_next.irq_stat[STAT_RB_POS] = 1'b1;
        end
        st_next.irq = (st_next.irq_stat & st_next.irq_mask) != 8'h00;
        // pin drive and analogue path
        st_next.pin_out  = st_next.data;
        st_next.pin_oe   = ~st_next.dir &
                           (~st_next.analog_sel | {8{st_next.read_back_enable}});
        st_next.adc_path = st_next.read_back_enable ? 8'hFF :
                           st_next.analog_sel;
        // rx source routing
        for (int i = 0; i < N_UART; i++) begin
            st_next.uart_rx[i] = st_reg.rx_sel[i] ? rx_alt_sync[i] : rx_def_sync[i];
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_reg                  <= '0;
            st_reg.data             <= PORT_RST;
            st_reg.dir              <= PORT_RST;
            st_reg.pin_out          <= PORT_RST;
            st_reg.rx_sel           <= RX_SEL_RST;
            st_reg.power            <= PWR_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA_OUT        = st_reg.rdata;
    assign PORT_PIN_OUT     = st_reg.pin_out;
    assign PORT_PIN_OE_OUT  = st_reg.pin_oe;
    assign ADC_PATH_ON_OUT  = st_reg.adc_path;
    assign UART_RX_OUT      = st_reg.uart_rx;
    assign READ_BACK_EN_OUT = st_reg.read_back_enable;
    assign SLEEP_OUT        = (st_reg.power == PWR_SLEEP);
    assign IRQ_OUT          = st_reg.irq;

    // checks
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    sequence key_write_s;
        WR_IN && ADDR_IN == OFF_UNLOCK && WDATA_IN == UNLOCK_KEY;
    endsequence

    sequence other_write_s;
        WR_IN && ADDR_IN == OFF_UNLOCK && WDATA_IN != UNLOCK_KEY;
    endsequence

    sequence asleep_s;
        st_reg.power == PWR_SLEEP && !(WR_IN && ADDR_IN == OFF_POWER);
    endsequence

    sequence wake_edge_s;
        (fall & st_reg.wake_en) != 8'h00;
    endsequence

    AST_KEY_ENABLES: assert property (
        key_write_s |=> READ_BACK_EN_OUT ##1 (READ_BACK_EN_OUT || $past(wr_hit_unlock)))
        else $error("key write did not enable read-back");

    AST_OTHER_DISABLES: assert property (
        other_write_s |=> !READ_BACK_EN_OUT && ADC_PATH_ON_OUT == $past(st_reg.analog_sel, 1))
        else $error("non-key value left read-back enabled");

    AST_NORMAL_DRIVE: assert property (
        (!st_next.read_back_enable) |=>
            PORT_PIN_OE_OUT == (~st_reg.dir & ~st_reg.analog_sel))
        else $error("test logic changed pin drive while disabled");

    AST_READBACK_PINS: assert property (
        (RD_IN && ADDR_IN == OFF_PORT_DATA && READ_BACK_EN_OUT) |=>
            RDATA_OUT == $past(pin_sync))
        else $error("read-back port read did not return pin levels");

    AST_OUTPUT_READ: assert property (
        (RD_IN && ADDR_IN == OFF_PORT_DATA && !READ_BACK_EN_OUT &&
         st_reg.analog_sel == 8'h00 && st_reg.outfn_sel == 8'hFF) |=>
            RDATA_OUT == ($past(st_reg.data) & ~$past(st_reg.dir)))
        else $error("output pin read value wrong");

    AST_PATH_OFF: assert property (
        (!st_next.read_back_enable && st_next.analog_sel == 8'h00) |=>
            ADC_PATH_ON_OUT == 8'h00)
        else $error("analogue path on without converter function");

    AST_PATH_FORCED: assert property (
        key_write_s |=> ADC_PATH_ON_OUT == 8'hFF && PORT_PIN_OE_OUT == ~st_reg.dir)
        else $error("read-back did not force analogue path");

    AST_BITOP_RMW: assert property (
        (WR_IN && ADDR_IN == OFF_BITOP && !WDATA_IN[BITOP_TGT_POS]) |=>
            st_reg.data == $past(bitop_val) && PORT_PIN_OUT == $past(bitop_val))
        else $error("bit operation did not write back the modified port");

    AST_WAKE: assert property (
        asleep_s and wake_edge_s |=> !SLEEP_OUT && st_reg.irq_stat[STAT_WAKE_POS])
        else $error("enabled falling edge did not wake");

    AST_RX_ROUTE: assert property (
        ##1 UART_RX_OUT == $past(st_reg.rx_sel & rx_alt_sync | ~st_reg.rx_sel & rx_def_sync))
        else $error("rx source routed from wrong pin");

    AST_RX_UPPER_ZERO: assert property (
        (RD_IN && ADDR_IN == OFF_RX_SEL) |=> RDATA_OUT[7:3] == 5'h0_0)
        else $error("unimplemented rx select bits not zero");

    AST_READ_ONE_CYCLE: assert property (
        !RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data outside the cycle after a read");
endmodule

// ===== dv/pin_partner.sv
// external circuitry on the port pins
`timescale 1ns/1ps
module pin_partner
    import port_rb_pkg::*;
#(
    parameter int SETTLE_NS = 2
) (
    input  wire logic [port_rb_pkg::N_PINS-1:0] pin_out_in,
    input  wire logic [port_rb_pkg::N_PINS-1:0] pin_oe_in,
    input  wire logic [port_rb_pkg::N_PINS-1:0] ext_level_in,
    output logic      [port_rb_pkg::N_PINS-1:0] pin_level_out
);
    // undriven pins follow the outside level
    assign #(SETTLE_NS) pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule

// ===== dv/tb.sv
// self-checking bench for the port read-back block
`timescale 1ns/1ps
module tb;
    import port_rb_pkg::*;
    logic       clk    = 1'b0;
    logic       arst_n = 1'b0;
    logic [3:0] addr   = 4'h0;
    logic [7:0] wdata  = 8'h00;
    logic       wr_s   = 1'b0;
    logic       rd_s   = 1'b0;
    logic [7:0] ext    = 8'hFF;
    logic [2:0] udef   = 3'h0;
    logic [2:0] ualt   = 3'h0;
    logic [7:0] seed   = 8'h4D;
    logic [7:0] rdata, pin_o, oe_o, adc_o, pin_i;
    logic [2:0] urx;
    logic       rb_en, sleep_o, irq_o;
    int         fails = 0;
    int         checks_done = 0;

    port_readback_selftest uut (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
        .PORT_PIN_IN(pin_i), .PORT_PIN_OUT(pin_o), .PORT_PIN_OE_OUT(oe_o),
        .ADC_PATH_ON_OUT(adc_o), .UART_RX_DEF_IN(udef), .UART_RX_ALT_IN(ualt),
        .UART_RX_OUT(urx), .READ_BACK_EN_OUT(rb_en), .SLEEP_OUT(sleep_o), .IRQ_OUT(irq_o));
    pin_partner #(.SETTLE_NS(2)) pins (.pin_out_in(pin_o), .pin_oe_in(oe_o),
        .ext_level_in(ext), .pin_level_out(pin_i));

    always #10 clk = ~clk;

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction
    // expected port read value
    function automatic logic [7:0] port_rd(input logic rb, input logic [7:0] pin, ana, of, dr, d);
        return rb ? pin : (~ana & ((of & ~dr & d) | (~of & pin)));
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        fails++;
        results();
    end

    initial begin
        logic [7:0] v, d, dr, an, of, e, key, oe, pin;
        logic       rb;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        settle(2);
        chk(pin_o, 8'hFF, "data reset");
        chk(oe_o, 8'h00, "drive reset");
        rd(OFF_PORT_DIR, v);
        chk(v, 8'hFF, "dir reset");
        rd(OFF_UNLOCK, v);
        chk(v, 8'h00, "unlock reset");
        wr(4'hF, 8'h5A);
        rd(4'hF, v);
        chk(v, 8'h00, "unmapped");
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            e = rnd();
            wr(OFF_RX_SEL, {v[7:3], i[2:0]});
            udef <= e[2:0];
            ualt <= e[5:3];
            settle(4);
            chk({5'h0, urx}, {5'h0, (i[2:0] & e[5:3]) | (~i[2:0] & e[2:0])}, "rx route");
            rd(OFF_RX_SEL, v);
            chk(v, {5'h0, i[2:0]}, "rx sel read");
        end
        $display("rx routing test done");
        for (int i = 0; i < 10; i++) begin
            d = rnd();
            dr = rnd();
            an = rnd();
            of = rnd();
            e = rnd();
            rb = i[0];
            if (i == 2) begin
                an = 8'h00;
                of = 8'hFF;
            end
            key = rb ? UNLOCK_KEY : rnd();
            if (!rb && key == UNLOCK_KEY) begin
                key = 8'h00;
            end
            wr(OFF_PORT_DATA, d);
            ext <= e;
            wr(OFF_PORT_DIR, dr);
            wr(OFF_ANALOG_SEL, an);
            wr(OFF_OUTFN_SEL, of);
            wr(OFF_UNLOCK, key);
            settle(4);
            oe = ~dr & (~an | {8{rb}});
            pin = (oe & d) | (~oe & e);
            chk({7'h0, rb_en}, {7'h0, rb}, "rb enable");
            chk(oe_o, oe, "drive enable");
            chk(adc_o, rb ? 8'hFF : an, "adc path");
            rd(OFF_PORT_DATA, v);
            chk(v, port_rd(rb, pin, an, of, dr, d), "port read");
        end
        rd(OFF_IRQ_STAT, v);
        chk(v, 8'h02, "read-back entry status");
        $display("read port test done");
        wr(OFF_UNLOCK, 8'h00);
        wr(OFF_ANALOG_SEL, 8'h00);
        wr(OFF_OUTFN_SEL, 8'h00);
        wr(OFF_PORT_DIR, 8'hF0);
        wr(OFF_PORT_DATA, 8'h00);
        e = rnd();
        ext <= e;
        settle(4);
        wr(OFF_BITOP, 8'h0A);
        settle(2);
        chk(pin_o, {e[7:4], 4'h4}, "bit set rmw");
        wr(OFF_BITOP, 8'h17);
        settle(2);
        chk(oe_o, 8'h8F, "bit clear dir");
        $display("bit op test done");
        wr(OFF_PORT_DIR, 8'hFF);
        wr(OFF_WAKE_EN, 8'h08);
        for (int m = 1; m >= 0; m--) begin
            wr(OFF_IRQ_MASK, m[7:0]);
            ext <= 8'hFF;
            settle(4);
            rd(OFF_IRQ_STAT, v);
            wr(OFF_POWER, 8'h01);
            settle(2);
            chk({7'h0, sleep_o}, 8'h01, "sleep entry");
            rd(OFF_POWER, v);
            chk(v, 8'h01, "power read");
            @(posedge clk);
            ext <= 8'hDF;
            settle(8);
            chk({7'h0, sleep_o}, 8'h01, "no wake disabled pin");
            @(posedge clk);
            ext <= 8'hD7;
            for (int k = 0; k < 8 && sleep_o !== 1'b0; k++) begin
                settle(1);
            end
            settle(1);
            chk({7'h0, sleep_o}, 8'h00, "wake on fall");
            chk({7'h0, irq_o}, m[7:0], "irq level");
            rd(OFF_IRQ_STAT, v);
            chk(v & 8'h01, 8'h01, "wake status");
            settle(2);
            chk({7'h0, irq_o}, 8'h00, "irq cleared");
        end
        $display("wake test done");
        results();
    end
endmodule
